// file: rtl/bridge_discard_params.svh
// register offsets, field positions, reset values and discard counts
// assumes an 8-bit byte address and 16-bit register data
`ifndef BRIDGE_DISCARD_PARAMS_SVH
`define BRIDGE_DISCARD_PARAMS_SVH

`define CTRL_OFS            8'h3e
`define IRQ_STAT_OFS        8'h40
`define IRQ_MASK_OFS        8'h42

`define RSVD_HI             15
`define RSVD_LO             12
`define ERR_EN_BIT          11
`define FLAG_BIT            10
`define DN_SEL_BIT          9
`define UP_SEL_BIT          8
`define B2B_BIT             7
`define SEC_RST_BIT         6

`define CTRL_RESET          16'h0000
`define IRQ_RESET           2'h0

`define IRQ_UP_BIT          0
`define IRQ_DN_BIT          1
`define BUSY_UP_BIT         4
`define BUSY_DN_BIT         5

`define DISCARD_LONG_CYCLES  32768
`define DISCARD_SHORT_CYCLES 1024

`endif

// file: rtl/bridge_discard_pkg.sv
// types shared by the discard timer and the bridge control block
// assumes the constants header for all numbers
package bridge_discard_pkg;

	typedef enum logic {
		TMR_IDLE,
		TMR_COUNT
	} timer_state_t;

	typedef logic [15:0] reg_word_t;

endpackage

// file: rtl/bridge_discard_timer_control.sv
// bridge control upper bits, both discard timers, reset and b2b gating
// assumes link clocks and the primary reset pin are asynchronous inputs,
// queue events are one-cycle pulses on i_clock
`timescale 1ns/1ps
`default_nettype none
`include "bridge_discard_params.svh"

module bridge_discard_timer_control #(
	parameter int unsigned LONG_COUNT  = `DISCARD_LONG_CYCLES,
	parameter int unsigned SHORT_COUNT = `DISCARD_SHORT_CYCLES
) (
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	input  wire logic        i_clk_en,
	input  wire logic [7:0]  i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output var  logic [15:0] o_rdata,
	input  wire logic        i_pri_pci_clk,
	input  wire logic        i_sec_pci_clk,
	input  wire logic        i_primary_bus_reset_in_n,
	input  wire logic        i_up_head_ready,
	input  wire logic        i_up_retry_done,
	input  wire logic        i_dn_head_ready,
	input  wire logic        i_dn_retry_done,
	input  wire logic        i_sec_b2b_request,
	output var  logic        o_up_discard,
	output var  logic        o_dn_discard,
	output var  logic        o_primary_system_error,
	output var  logic        o_secondary_bus_reset_n,
	output var  logic        o_fast_b2b_grant,
	output var  logic        o_irq
);
	// input synchronisers and link clock edge detect
	logic [2:0] meta_q, meta_d;
	logic [2:0] sync_q, sync_d;
	logic [1:0] prev_q, prev_d;
	logic       up_tick;
	logic       dn_tick;
	logic       prim_rst_active;

	always_comb begin
		meta_d = {i_primary_bus_reset_in_n, i_sec_pci_clk, i_pri_pci_clk};
		sync_d = meta_q;
		prev_d = sync_q[1:0];
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_q <= 3'h0;
			sync_q <= 3'h0;
			prev_q <= 2'h0;
		end else if (i_clk_en) begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			prev_q <= prev_d;
		end
	end

	assign up_tick         = sync_q[0] & ~prev_q[0];
	assign dn_tick         = sync_q[1] & ~prev_q[1];
	assign prim_rst_active = ~sync_q[2];

	// control register fields
	logic err_en_q, err_en_d;
	logic flag_q, flag_d;
	logic dn_sel_q, dn_sel_d;
	logic up_sel_q, up_sel_d;
	logic b2b_q, b2b_d;
	logic sec_rst_q, sec_rst_d;
	logic [1:0] irq_stat_q, irq_stat_d;
	logic [1:0] irq_mask_q, irq_mask_d;
	logic [15:0] rdata_q, rdata_d;
	logic        up_busy;
	logic        dn_busy;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	function automatic bridge_discard_pkg::reg_word_t ctrl_word(
		input logic e, input logic f, input logic d,
		input logic u, input logic b, input logic s);
		bridge_discard_pkg::reg_word_t w;
		w = 16'h0000;
		w[`ERR_EN_BIT]  = e;
		w[`FLAG_BIT]    = f;
		w[`DN_SEL_BIT]  = d;
		w[`UP_SEL_BIT]  = u;
		w[`B2B_BIT]     = b;
		w[`SEC_RST_BIT] = s;
		ctrl_word = w;
	endfunction

	always_comb begin
		logic wr_ctrl;
		logic any_discard;
		wr_ctrl     = i_wr && hit(i_addr, `CTRL_OFS);
		any_discard = o_up_discard | o_dn_discard;
		err_en_d    = err_en_q;
		dn_sel_d    = dn_sel_q;
		up_sel_d    = up_sel_q;
		b2b_d       = b2b_q;
		sec_rst_d   = sec_rst_q;
		flag_d      = flag_q;
		irq_mask_d  = irq_mask_q;
		irq_stat_d  = irq_stat_q;
		rdata_d     = 16'h0000;
		if (wr_ctrl) begin
			err_en_d  = i_wdata[`ERR_EN_BIT];
			dn_sel_d  = i_wdata[`DN_SEL_BIT];
			up_sel_d  = i_wdata[`UP_SEL_BIT];
			b2b_d     = i_wdata[`B2B_BIT];
			sec_rst_d = i_wdata[`SEC_RST_BIT];
			if (i_wdata[`FLAG_BIT]) begin
				flag_d = 1'b0;
			end
		end
		if (any_discard) begin
			flag_d = 1'b1;
		end
		if (i_wr && hit(i_addr, `IRQ_MASK_OFS)) begin
			irq_mask_d = i_wdata[1:0];
		end
		if (i_rd && hit(i_addr, `IRQ_STAT_OFS)) begin
			irq_stat_d = 2'h0;
		end
		if (o_up_discard) begin
			irq_stat_d[`IRQ_UP_BIT] = 1'b1;
		end
		if (o_dn_discard) begin
			irq_stat_d[`IRQ_DN_BIT] = 1'b1;
		end
		if (i_rd) begin
			if (hit(i_addr, `CTRL_OFS)) begin
				rdata_d = ctrl_word(err_en_q, flag_q, dn_sel_q, up_sel_q, b2b_q, sec_rst_q);
			end else if (hit(i_addr, `IRQ_STAT_OFS)) begin
				rdata_d[1:0]          = irq_stat_q;
				rdata_d[`BUSY_UP_BIT] = up_busy;
				rdata_d[`BUSY_DN_BIT] = dn_busy;
			end else if (hit(i_addr, `IRQ_MASK_OFS)) begin
				rdata_d[1:0] = irq_mask_q;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			err_en_q   <= 1'(`CTRL_RESET >> `ERR_EN_BIT);
			flag_q     <= 1'b0;
			dn_sel_q   <= 1'b0;
			up_sel_q   <= 1'b0;
			b2b_q      <= 1'b0;
			sec_rst_q  <= 1'b0;
			irq_stat_q <= `IRQ_RESET;
			irq_mask_q <= `IRQ_RESET;
			rdata_q    <= 16'h0000;
		end else if (i_clk_en) begin
			err_en_q   <= err_en_d;
			flag_q     <= flag_d;
			dn_sel_q   <= dn_sel_d;
			up_sel_q   <= up_sel_d;
			b2b_q      <= b2b_d;
			sec_rst_q  <= sec_rst_d;
			irq_stat_q <= irq_stat_d;
			irq_mask_q <= irq_mask_d;
			rdata_q    <= rdata_d;
		end
	end

	assign o_rdata = rdata_q;

	// upstream timer on primary clocks, downstream on secondary clocks
	discard_timer #(
		.LONG_COUNT  (LONG_COUNT),
		.SHORT_COUNT (SHORT_COUNT)
	) up_timer (
		.i_clock     (i_clock),
		.i_rst_n     (i_rst_n),
		.i_clk_en    (i_clk_en),
		.i_tick      (up_tick),
		.i_start     (i_up_head_ready),
		.i_retry     (i_up_retry_done),
		.i_short_sel (up_sel_q),
		.o_discard   (o_up_discard),
		.o_busy      (up_busy)
	);

	discard_timer #(
		.LONG_COUNT  (LONG_COUNT),
		.SHORT_COUNT (SHORT_COUNT)
	) dn_timer (
		.i_clock     (i_clock),
		.i_rst_n     (i_rst_n),
		.i_clk_en    (i_clk_en),
		.i_tick      (dn_tick),
		.i_start     (i_dn_head_ready),
		.i_retry     (i_dn_retry_done),
		.i_short_sel (dn_sel_q),
		.o_discard   (o_dn_discard),
		.o_busy      (dn_busy)
	);

	// pin and interrupt outputs
	logic sys_err_q, sys_err_d;
	logic sec_rst_n_q, sec_rst_n_d;
	logic grant_q, grant_d;
	logic irq_q, irq_d;

	always_comb begin
		sys_err_d   = err_en_q & (o_up_discard | o_dn_discard);
		sec_rst_n_d = ~(sec_rst_q | prim_rst_active);
		grant_d     = b2b_q & i_sec_b2b_request;
		irq_d       = |(irq_stat_d & irq_mask_q);
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sys_err_q   <= 1'b0;
			sec_rst_n_q <= 1'b0;
			grant_q     <= 1'b0;
			irq_q       <= 1'b0;
		end else if (i_clk_en) begin
			sys_err_q   <= sys_err_d;
			sec_rst_n_q <= sec_rst_n_d;
			grant_q     <= grant_d;
			irq_q       <= irq_d;
		end
	end

	assign o_primary_system_error  = sys_err_q;
	assign o_secondary_bus_reset_n = sec_rst_n_q;
	assign o_fast_b2b_grant        = grant_q;
	assign o_irq                   = irq_q;

	// checks
	AST_RSVD_ZERO: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_clk_en && i_rd && i_addr == `CTRL_OFS |=> o_rdata[15:12] == 4'h0)
		else $error("reserved control bits read non-zero");
	AST_ERR_ON_DISCARD: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_clk_en && err_en_q && (o_up_discard || o_dn_discard) |=> o_primary_system_error)
		else $error("system error missing after discard");
	AST_NO_ERR_DISABLED: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_clk_en && !err_en_q |=> !o_primary_system_error)
		else $error("system error raised while disabled");
	AST_FLAG_SET: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_clk_en && (o_up_discard || o_dn_discard) |=> flag_q)
		else $error("discard flag not set after discard");
	AST_FLAG_READBACK: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_clk_en && i_rd && i_addr == `CTRL_OFS |=> o_rdata[`FLAG_BIT] == $past(flag_q))
		else $error("discard flag not reported on read");
	AST_STATUS_SET: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_clk_en && (o_up_discard || o_dn_discard)
		|=> (irq_stat_q[`IRQ_UP_BIT] || !$past(o_up_discard))
		&& (irq_stat_q[`IRQ_DN_BIT] || !$past(o_dn_discard)))
		else $error("discard status bit not set");
	AST_FLAG_W1C: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_clk_en && i_wr && i_addr == `CTRL_OFS && i_wdata[`FLAG_BIT]
		&& !o_up_discard && !o_dn_discard |=> !flag_q)
		else $error("discard flag not cleared by write of one");
	AST_FLAG_HOLD: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_clk_en && flag_q && !(i_wr && i_addr == `CTRL_OFS && i_wdata[`FLAG_BIT])
		|=> flag_q)
		else $error("discard flag lost without a write of one");
	AST_SEC_RST_BIT: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_clk_en && sec_rst_q |=> !o_secondary_bus_reset_n)
		else $error("secondary reset released while control bit set");
	AST_PRIM_RST: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_clk_en && prim_rst_active |=> !o_secondary_bus_reset_n)
		else $error("secondary reset released during primary reset");
	AST_SEC_RST_RELEASE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_clk_en && !sec_rst_q && !prim_rst_active |=> o_secondary_bus_reset_n)
		else $error("secondary reset held with bit and primary reset clear");
	AST_B2B_GATE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		o_fast_b2b_grant |-> $past(b2b_q) && $past(i_sec_b2b_request))
		else $error("fast back-to-back granted while disabled");

	COV_UP_DISCARD: cover property (@(posedge i_clock) disable iff (!i_rst_n)
		o_up_discard ##1 o_primary_system_error);
	COV_DN_DELIVERED: cover property (@(posedge i_clock) disable iff (!i_rst_n)
		dn_busy && i_dn_retry_done);
	COV_IRQ: cover property (@(posedge i_clock) disable iff (!i_rst_n)
		o_irq ##1 i_rd && i_addr == `IRQ_STAT_OFS);
	COV_PRIM_RST: cover property (@(posedge i_clock) disable iff (!i_rst_n)
		prim_rst_active && !sec_rst_q ##1 !o_secondary_bus_reset_n);
	COV_B2B_GRANT: cover property (@(posedge i_clock) disable iff (!i_rst_n)
		b2b_q && i_sec_b2b_request ##1 o_fast_b2b_grant);
endmodule
`default_nettype wire

// file: rtl/discard_timer.sv
// one delayed-completion discard timer counting link clock ticks
// assumes i_tick is a one-cycle pulse per link clock rising edge
`timescale 1ns/1ps
`default_nettype none
`include "bridge_discard_params.svh"
module discard_timer #(
	parameter int unsigned LONG_COUNT  = `DISCARD_LONG_CYCLES,
	parameter int unsigned SHORT_COUNT = `DISCARD_SHORT_CYCLES
) (
	input  wire logic i_clock,
	input  wire logic i_rst_n,
	input  wire logic i_clk_en,
	input  wire logic i_tick,
	input  wire logic i_start,
	input  wire logic i_retry,
	input  wire logic i_short_sel,
	output var  logic o_discard,
	output var  logic o_busy
);
	localparam logic [15:0] LONG_LEN  = 16'(LONG_COUNT - 1);
	localparam logic [15:0] SHORT_LEN = 16'(SHORT_COUNT - 1);

	bridge_discard_pkg::timer_state_t state_q, state_d;
	logic [15:0] cnt_q, cnt_d;
	logic [15:0] last_q, last_d;
	logic        discard_q, discard_d;

	always_comb begin
		state_d   = state_q;
		cnt_d     = cnt_q;
		last_d    = last_q;
		discard_d = 1'b0;
		unique case (state_q)
			bridge_discard_pkg::TMR_IDLE: begin
				if (i_start) begin
					state_d = bridge_discard_pkg::TMR_COUNT;
					cnt_d   = 16'h0000;
					last_d  = i_short_sel ? SHORT_LEN : LONG_LEN;
				end
			end
			bridge_discard_pkg::TMR_COUNT: begin
				if (i_retry) begin
					state_d = bridge_discard_pkg::TMR_IDLE;
					cnt_d   = 16'h0000;
				end else if (i_tick) begin
					if (cnt_q == last_q) begin
						state_d   = bridge_discard_pkg::TMR_IDLE;
						cnt_d     = 16'h0000;
						discard_d = 1'b1;
					end else begin
						cnt_d = cnt_q + 16'h0001;
					end
				end
			end
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q   <= bridge_discard_pkg::TMR_IDLE;
			cnt_q     <= 16'h0000;
			last_q    <= 16'h0000;
			discard_q <= 1'b0;
		end else if (i_clk_en) begin
			state_q   <= state_d;
			cnt_q     <= cnt_d;
			last_q    <= last_d;
			discard_q <= discard_d;
		end
	end

	assign o_discard = discard_q;
	assign o_busy    = (state_q == bridge_discard_pkg::TMR_COUNT);

	// ticks seen since start, for checking only
	logic [16:0] hlp_ticks_q;
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hlp_ticks_q <= 17'h00000;
		end else if (i_clk_en) begin
			if (!o_busy) begin
				hlp_ticks_q <= 17'h00000;
			end else if (i_tick && !i_retry) begin
				hlp_ticks_q <= hlp_ticks_q + 17'h00001;
			end
		end
	end

	AST_DISCARD_LENGTH: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		o_discard |-> (hlp_ticks_q == 17'(LONG_COUNT) || hlp_ticks_q == 17'(SHORT_COUNT)))
		else $error("discard after wrong number of link clocks");
	AST_RETRY_STOPS: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_clk_en && o_busy && i_retry |=> !o_busy && !o_discard)
		else $error("retry did not stop the discard timer");
	AST_START_ONLY: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_clk_en && !o_busy && !i_start |=> !o_busy)
		else $error("timer ran without a completion at queue head");
endmodule
`default_nettype wire

// file: verif/bridge_discard_timer_control_test.sv
// self-checking bench for bridge control bits and both discard timers
// assumes short discard counts set through the top parameters
`timescale 1ns/1ps
`default_nettype none
`include "bridge_discard_params.svh"
module bridge_discard_timer_control_test;
	localparam int unsigned LONG_N  = 16;
	localparam int unsigned SHORT_N = 4;
	logic        i_clock = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
	logic        pri_run = 1'b0, sec_run = 1'b0, primary_bus_reset_in_n = 1'b1, b2b_req = 1'b0;
	logic [3:0]  ev      = 4'h0;
	logic [7:0]  i_addr  = 8'h00;
	logic [15:0] i_wdata = 16'h0000;
	logic [15:0] rdata, d, c;
	logic        up_disc, dn_disc, serr, secondary_bus_reset_n, grant, irq, pri_clk, sec_clk;
	logic        up, sel, err;
	int          bad_count = 0, n_tests = 0, edges = 0, k, hits;

	bridge_discard_timer_control #(.LONG_COUNT(LONG_N), .SHORT_COUNT(SHORT_N)) dut (
		.i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_en(1'b1), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
		.i_pri_pci_clk(pri_clk), .i_sec_pci_clk(sec_clk),
		.i_primary_bus_reset_in_n(primary_bus_reset_in_n), .i_up_head_ready(ev[0]),
		.i_up_retry_done(ev[1]), .i_dn_head_ready(ev[2]), .i_dn_retry_done(ev[3]),
		.i_sec_b2b_request(b2b_req), .o_up_discard(up_disc), .o_dn_discard(dn_disc),
		.o_primary_system_error(serr), .o_secondary_bus_reset_n(secondary_bus_reset_n),
		.o_fast_b2b_grant(grant), .o_irq(irq));

	pci_link_model link (.i_pri_run(pri_run), .i_sec_run(sec_run),
		.o_pri_clk(pri_clk), .o_sec_clk(sec_clk));

	always #2 i_clock = ~i_clock;
	always @(posedge pri_clk or posedge sec_clk) edges++;

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tdone(input string s);
		$display("test %s done", s);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge i_clock);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge i_clock);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1;
		v = rdata;
	endtask

	task automatic pulse(input logic [3:0] m);
		@(posedge i_clock);
		ev <= m;
		@(posedge i_clock);
		ev <= 4'h0;
		#1;
	endtask

	// start one timer, let its link clock run until the discard pulse
	task automatic run_timer(input logic u, input int n, input logic e, input logic q);
		pulse(u ? 4'h1 : 4'h4);
		edges = 0;
		pri_run = u;
		sec_run = !u;
		for (k = 0; k < 4000 && !(up_disc || dn_disc); k++) cyc(1);
		pri_run = 1'b0;
		sec_run = 1'b0;
		if (k == 4000) begin
			bad_count++;
			final_report();
		end
		check(16'(edges), 16'(n));
		check({14'h0, up_disc, dn_disc}, u ? 16'h2 : 16'h1);
		cyc(1);
		check(16'(serr), 16'(e));
		check(16'(irq), 16'(q));
		rd(`IRQ_STAT_OFS, d);
		check(d, u ? 16'h1 : 16'h2);
	endtask

	initial begin
		repeat (19) @(posedge i_clock);
		#1;
		check(16'(secondary_bus_reset_n), 16'h0);
		@(posedge i_clock) i_rst_n <= 1'b1;
		cyc(6);
		rd(`CTRL_OFS, d);
		check(d, `CTRL_RESET);
		rd(`IRQ_STAT_OFS, d);
		check(d, 16'h0);
		rd(`IRQ_MASK_OFS, d);
		check(d, 16'h0);
		check(16'(secondary_bus_reset_n), 16'h1);
		tdone("reset");

		@(posedge i_clock) b2b_req <= 1'b1;
		wr(`CTRL_OFS, 16'hf0c0);
		wr(8'h50, 16'hffff);
		rd(8'h50, d);
		check(d, 16'h0);
		rd(`CTRL_OFS, d);
		check(d, 16'h00c0);
		check(16'(secondary_bus_reset_n), 16'h0);
		check(16'(grant), 16'h1);
		wr(`CTRL_OFS, 16'h0000);
		cyc(3);
		check(16'(secondary_bus_reset_n), 16'h1);
		check(16'(grant), 16'h0);
		@(posedge i_clock) primary_bus_reset_in_n <= 1'b0;
		cyc(6);
		check(16'(secondary_bus_reset_n), 16'h0);
		@(posedge i_clock) primary_bus_reset_in_n <= 1'b1;
		cyc(6);
		check(16'(secondary_bus_reset_n), 16'h1);
		wr(`IRQ_MASK_OFS, 16'hffff);
		rd(`IRQ_MASK_OFS, d);
		check(d, 16'h0003);
		tdone("registers");

		// both directions, both lengths, error enable and mask toggled
		for (int i = 0; i < 4; i++) begin
			up = i[0];
			sel = !i[1];
			err = i[0] ^ i[1];
			c = {4'h0, err, 1'b1, !up && sel, up && sel, 8'h00};
			wr(`IRQ_MASK_OFS, (i == 2) ? 16'h0 : 16'h3);
			wr(`CTRL_OFS, c);
			run_timer(up, sel ? SHORT_N : LONG_N, err, i != 2);
			rd(`CTRL_OFS, d);
			check(d, c);
			wr(`CTRL_OFS, c & 16'hfbff);
			rd(`CTRL_OFS, d);
			check(d, c);
			wr(`CTRL_OFS, c);
			rd(`CTRL_OFS, d);
			check(d, c & 16'hfbff);
			tdone("discard");
		end

		// retry halfway, then a fresh full count
		wr(`CTRL_OFS, 16'h0a00);
		pulse(4'h4);
		edges = 0;
		sec_run = 1'b1;
		for (k = 0; k < 400 && edges < 2; k++) cyc(1);
		if (k == 400) begin
			bad_count++;
			final_report();
		end
		rd(`IRQ_STAT_OFS, d);
		check(d, 16'h0020);
		pulse(4'h8);
		rd(`IRQ_STAT_OFS, d);
		check(d, 16'h0);
		hits = 0;
		for (k = 0; k < 80 * SHORT_N; k++) begin
			cyc(1);
			hits += int'(up_disc | dn_disc | serr);
		end
		sec_run = 1'b0;
		check(16'(hits), 16'h0);
		run_timer(1'b0, SHORT_N, 1'b1, 1'b1);
		tdone("retry");
		final_report();
	end
endmodule
`default_nettype wire

// file: verif/pci_link_model.sv
// far-side link clocks of the primary and secondary buses
// assumes the bench raises a run flag while a delayed completion waits, and after a retry to check that no discard follows
`timescale 1ns/1ps
`default_nettype none
module pci_link_model (
	input  wire logic i_pri_run,
	input  wire logic i_sec_run,
	output var  logic o_pri_clk,
	output var  logic o_sec_clk
);
	initial begin
		o_pri_clk = 1'b0;
		o_sec_clk = 1'b0;
		#1.3;
		forever begin
			#80;
			// clock parks low outside a frame
			o_pri_clk = (i_pri_run || o_pri_clk) ? ~o_pri_clk : 1'b0;
			o_sec_clk = (i_sec_run || o_sec_clk) ? ~o_sec_clk : 1'b0;
		end
	end
endmodule
`default_nettype wire
